// ### hw/les_pkg.sv
// les_pkg: register indices, field positions, reset values for the line error register group.
// assumes registers sit one per 32-bit word, byte address = 4 * index.
package les_pkg;

	localparam int NUM_CH = 16;
	localparam int IDX_W = 11;
	localparam int FLAG_W = 6;

	// per-channel group, channel 1 at base, channels 2..15 follow at the stride
	localparam logic [IDX_W-1:0] IDX_CH_STRIDE = 11'h040;
	localparam logic [IDX_W-1:0] IDX_CH_LAST = 11'h3c0;
	localparam logic [5:0] SUB_IRQ_STATUS = 6'h22;
	localparam logic [5:0] SUB_COUNT_LOW = 6'h23;
	localparam logic [5:0] SUB_COUNT_HIGH = 6'h24;

	// channel 0 group
	localparam logic [IDX_W-1:0] IDX_CH0_COUNT_LOW = 11'h7e3;
	localparam logic [IDX_W-1:0] IDX_CH0_COUNT_HIGH = 11'h7e4;
	localparam logic [IDX_W-1:0] IDX_JITTER_CONFIG = 11'h7e5;
	localparam logic [IDX_W-1:0] IDX_POS_PEAK_LOW = 11'h7e6;
	localparam logic [IDX_W-1:0] IDX_POS_PEAK_HIGH = 11'h7e7;
	localparam logic [IDX_W-1:0] IDX_NEG_PEAK_LOW = 11'h7e8;
	localparam logic [IDX_W-1:0] IDX_NEG_PEAK_HIGH = 11'h7e9;

	// control and interrupt summary
	localparam logic [IDX_W-1:0] IDX_ERROR_CONFIG = 11'h7f0;
	localparam logic [IDX_W-1:0] IDX_EDGE_SELECT = 11'h7f1;
	localparam logic [IDX_W-1:0] IDX_IRQ_SUMMARY = 11'h7f2;
	localparam logic [IDX_W-1:0] IDX_IRQ_CLEAR = 11'h7f3;
	localparam logic [IDX_W-1:0] IDX_IRQ_ENABLE = 11'h7f4;

	// status flag positions
	localparam int BIT_SYS_BIPOLAR = 5;
	localparam int BIT_LINE_BIPOLAR = 4;
	localparam int BIT_SYS_EXCESS_ZERO = 3;
	localparam int BIT_LINE_EXCESS_ZERO = 2;
	localparam int BIT_PATTERN_ERROR = 1;
	localparam int BIT_COUNT_OVERFLOW = 0;

	// jitter config fields
	localparam int BIT_MANUAL_TRIGGER = 2;
	localparam int BIT_PERIOD_SELECT = 1;
	localparam int BIT_BAND_SELECT = 0;

	// error config fields
	localparam int BIT_COUNT_UPDATE_SELECT = 1;
	localparam int BIT_COUNT_LOAD_REQUEST = 0;

	localparam int BIT_JITTER_DONE = 0;

	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [FLAG_W-1:0] RST_FLAGS = 6'h00;
	localparam logic [15:0] RST_COUNT = 16'h0000;
	localparam logic [11:0] RST_PEAK = 12'h000;
	localparam logic [15:0] RST_IRQ_ENABLE = 16'hffff;
	localparam logic [15:0] RST_IRQ_SUMMARY = 16'h0000;
	localparam logic [15:0] COUNT_MAX = 16'hffff;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

endpackage

// ### hw/les_flag_bank.sv
// les_flag_bank: six sticky interrupt flags of one channel.
// assumes level sources synchronous to clk_sys; overflow arrives as a one-cycle pulse.
`timescale 1ns/1ps
module les_flag_bank (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [les_pkg::FLAG_W-1:1] src_level,
	input wire logic overflow_pulse,
	input wire logic [les_pkg::FLAG_W-1:0] edge_any,
	input wire logic [les_pkg::FLAG_W-1:0] clear_ones,
	output logic [les_pkg::FLAG_W-1:0] flags
);
	import les_pkg::*;

	logic [FLAG_W-1:1] src_prev;
	logic [FLAG_W-1:0] event_hit;

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			src_prev <= '0;
		end else begin
			src_prev <= src_level;
		end
	end

	// rise always sets; fall sets only where either edge is chosen
	always_comb begin
		event_hit[FLAG_W-1:1] = (src_level & ~src_prev)
			| (~src_level & src_prev & edge_any[FLAG_W-1:1]);
		event_hit[BIT_COUNT_OVERFLOW] = overflow_pulse;
	end

	// set wins over a write-one clear in the same cycle
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			flags <= RST_FLAGS;
		end else begin
			flags <= (flags & ~clear_ones) | event_hit;
		end
	end

endmodule

// ### hw/les_err_counter.sv
// les_err_counter: internal error accumulator and its readable snapshot for one channel.
// assumes err_pulse is one cycle per error; load is one cycle per counting round.
`timescale 1ns/1ps
module les_err_counter (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic err_pulse,
	input wire logic load,
	output logic [15:0] count,
	output logic overflow_pulse
);
	import les_pkg::*;

	logic [15:0] accum;

	// accumulator saturates; a new round starts from the error seen at the load
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			accum <= RST_COUNT;
		end else if (load) begin
			accum <= {15'h0000, err_pulse};
		end else if (err_pulse && accum != COUNT_MAX) begin
			accum <= accum + 16'h0001;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			overflow_pulse <= 1'b0;
		end else begin
			overflow_pulse <= err_pulse && !load && accum == COUNT_MAX;
		end
	end

	// snapshot overwritten each round
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			count <= RST_COUNT;
		end else if (load) begin
			count <= accum;
		end
	end

endmodule

// ### hw/les_line_error_regs.sv
// les_line_error_regs: per-channel error status, error counts and channel 0 jitter config.
// assumes an AXI4-Lite master on clk_sys; event sources and jitter peaks come from
// the line logic, synchronous to clk_sys.
//
// Overview of operation
// - status register repeats for channels 1..15 at 0x40 index steps.
// - bit 5 sets on system bipolar violation, write one clears, resets zero.
// - bit 4 sets on line bipolar violation, write one clears, resets zero.
// - bit 3 sets on system excess zeros, write one clears, resets zero.
// - bit 2 sets on line excess zeros, write one clears, resets zero.
// - bit 1 sets on test pattern error, write one clears, resets zero.
// - bit 0 sets on error count overflow, write one clears, resets zero.
// - status bits 7 and 6 are reserved and read zero.
// - 16-bit error count read as low and high bytes, every channel, reset zero.
// - counter mode bit 1 picks automatic or manual count loading.
// - channel 0 jitter config register is read/write, resets zero, bits 7..3 reserved.
// - period select bit 1: zero manual stop, one fixed one-second period.
// - band select bit 0: zero wide band, one high band.
// - positive peak is 12 bits over two registers, value/16 gives UIpp.
// - edge select zero: rising sets flag; one: either transition sets flag.
`timescale 1ns/1ps
module les_line_error_regs (
	input wire logic clk_sys,
	input wire logic rst,
	// axi4-lite slave
	input wire logic [12:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [12:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// status sources, index is the channel
	input wire logic [les_pkg::NUM_CH-1:1] sys_bipolar_viol,
	input wire logic [les_pkg::NUM_CH-1:1] line_bipolar_viol,
	input wire logic [les_pkg::NUM_CH-1:1] sys_excess_zero,
	input wire logic [les_pkg::NUM_CH-1:1] line_excess_zero,
	input wire logic [les_pkg::NUM_CH-1:1] pattern_error,
	input wire logic [les_pkg::NUM_CH-1:0] err_pulse,
	input wire logic count_round_end,
	// channel 0 jitter measurement
	input wire logic [11:0] jit_pos_peak,
	input wire logic [11:0] jit_neg_peak,
	input wire logic jit_second_tick,
	output logic period_select,
	output logic band_select,
	output logic count_update_select,
	output logic irq
);
	import les_pkg::*;

	typedef logic [FLAG_W-1:0] les_flags_t;

	// channel number 1..15 of a per-channel index, zero when outside the groups
	function automatic logic [3:0] chan_of(input logic [IDX_W-1:0] idx);
		logic [3:0] ch;
		ch = 4'h0;
		if (idx < IDX_CH_LAST) begin
			ch = 4'(idx[9:6]) + 4'h1;
		end
		return ch;
	endfunction

	function automatic logic [7:0] low_byte(input logic [15:0] v);
		return v[7:0];
	endfunction

	function automatic logic [7:0] high_byte(input logic [15:0] v);
		return v[15:8];
	endfunction

	// write channel state
	logic aw_held;
	logic w_held;
	logic [IDX_W-1:0] wr_idx;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic wr_go;
	logic [3:0] wr_ch;
	logic wr_hit;

	// register contents
	logic [2:0] jitter_config;
	logic manual_trigger_prev;
	logic [11:0] pos_peak;
	logic [11:0] neg_peak;
	logic [FLAG_W-1:0] edge_select;
	logic count_load_request;
	logic [15:0] irq_enable;
	logic jitter_done;
	logic jitter_capture;
	logic count_load;

	les_flags_t flags [NUM_CH];
	les_flags_t clear_ones [NUM_CH];
	logic [15:0] err_count [NUM_CH];
	logic [NUM_CH-1:0] count_overflow;
	logic [NUM_CH-1:0] chan_any;
	logic [15:0] irq_summary;

	logic [31:0] next_rdata;
	logic [1:0] next_rresp;

	// ---------- write address / data capture, either order ----------
	assign wr_go = aw_held && w_held && !s_axi_bvalid;
	assign wr_ch = chan_of(wr_idx);

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			aw_held <= 1'b0;
			wr_idx <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			wr_idx <= s_axi_awaddr[12:2];
		end else if (wr_go) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			w_held <= 1'b0;
			wr_data <= '0;
			wr_strb <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			wr_data <= s_axi_wdata;
			wr_strb <= s_axi_wstrb;
		end else if (wr_go) begin
			w_held <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !wr_go;
			s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) && !wr_go;
		end
	end

	// writable targets and whether the index is mapped for writing
	always_comb begin
		wr_hit = 1'b0;
		if (wr_ch != 4'h0) begin
			wr_hit = wr_idx[5:0] == SUB_IRQ_STATUS;
		end
		if (wr_idx == IDX_JITTER_CONFIG || wr_idx == IDX_ERROR_CONFIG
			|| wr_idx == IDX_EDGE_SELECT || wr_idx == IDX_IRQ_CLEAR
			|| wr_idx == IDX_IRQ_ENABLE) begin
			wr_hit = 1'b1;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ---------- status write-one-clear strobes ----------
	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			clear_ones[c] = '0;
			if (wr_go && wr_strb[0] && wr_ch == 4'(c) && wr_idx[5:0] == SUB_IRQ_STATUS) begin
				clear_ones[c] = wr_data[FLAG_W-1:0];
			end
		end
	end

	// ---------- per-channel flags and counters ----------
	assign flags[0] = RST_FLAGS;

	generate
		for (genvar c = 1; c < NUM_CH; c++) begin : g_chan
			les_flag_bank u_flags (
				.clk_sys(clk_sys),
				.rst(rst),
				.src_level({sys_bipolar_viol[c], line_bipolar_viol[c], sys_excess_zero[c],
					line_excess_zero[c], pattern_error[c]}),
				.overflow_pulse(count_overflow[c]),
				.edge_any(edge_select),
				.clear_ones(clear_ones[c]),
				.flags(flags[c])
			);
		end
		for (genvar c = 0; c < NUM_CH; c++) begin : g_count
			les_err_counter u_count (
				.clk_sys(clk_sys),
				.rst(rst),
				.err_pulse(err_pulse[c]),
				.load(count_load),
				.count(err_count[c]),
				.overflow_pulse(count_overflow[c])
			);
		end
	endgenerate

	// automatic: round end loads; manual: software request loads
	assign count_load = count_update_select ? count_load_request : count_round_end;

	// ---------- error config and edge select ----------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			count_update_select <= 1'b0;
			count_load_request <= 1'b0;
		end else begin
			count_load_request <= 1'b0;
			if (wr_go && wr_strb[0] && wr_idx == IDX_ERROR_CONFIG) begin
				count_update_select <= wr_data[BIT_COUNT_UPDATE_SELECT];
				count_load_request <= wr_data[BIT_COUNT_LOAD_REQUEST];
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			edge_select <= RST_FLAGS;
		end else if (wr_go && wr_strb[0] && wr_idx == IDX_EDGE_SELECT) begin
			edge_select <= wr_data[FLAG_W-1:0];
		end
	end

	// ---------- jitter measurement config ----------
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			jitter_config <= 3'h0;
		end else if (wr_go && wr_strb[0] && wr_idx == IDX_JITTER_CONFIG) begin
			jitter_config <= wr_data[2:0];
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			period_select <= 1'b0;
			band_select <= 1'b0;
			manual_trigger_prev <= 1'b0;
		end else begin
			period_select <= jitter_config[BIT_PERIOD_SELECT];
			band_select <= jitter_config[BIT_BAND_SELECT];
			manual_trigger_prev <= jitter_config[BIT_MANUAL_TRIGGER];
		end
	end

	// manual: stop bit rising edge; automatic: one-second tick
	assign jitter_capture = jitter_config[BIT_PERIOD_SELECT] ? jit_second_tick
		: (jitter_config[BIT_MANUAL_TRIGGER] && !manual_trigger_prev);

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pos_peak <= RST_PEAK;
			neg_peak <= RST_PEAK;
		end else if (jitter_capture) begin
			pos_peak <= jit_pos_peak;
			neg_peak <= jit_neg_peak;
		end
	end

	// ---------- interrupt summary ----------
	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			chan_any[c] = |flags[c];
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			jitter_done <= 1'b0;
		end else if (jitter_capture) begin
			jitter_done <= 1'b1;
		end else if (wr_go && wr_strb[0] && wr_idx == IDX_IRQ_CLEAR
			&& wr_data[BIT_JITTER_DONE]) begin
			jitter_done <= 1'b0;
		end
	end

	assign irq_summary = {chan_any[NUM_CH-1:1], jitter_done};

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			irq_enable <= RST_IRQ_ENABLE;
		end else if (wr_go && wr_strb[0] && wr_idx == IDX_IRQ_ENABLE) begin
			irq_enable <= {wr_strb[1] ? wr_data[15:8] : irq_enable[15:8], wr_data[7:0]};
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_summary & irq_enable);
		end
	end

	// ---------- read path ----------
	always_comb begin
		logic [IDX_W-1:0] idx;
		logic [3:0] ch;
		idx = s_axi_araddr[12:2];
		ch = chan_of(idx);
		next_rdata = 32'h0000_0000;
		next_rresp = RESP_OKAY;
		if (ch != 4'h0 && idx[5:0] == SUB_IRQ_STATUS) begin
			next_rdata[7:0] = {2'b00, flags[ch]};
		end else if (ch != 4'h0 && idx[5:0] == SUB_COUNT_LOW) begin
			next_rdata[7:0] = low_byte(err_count[ch]);
		end else if (ch != 4'h0 && idx[5:0] == SUB_COUNT_HIGH) begin
			next_rdata[7:0] = high_byte(err_count[ch]);
		end else begin
			unique case (idx)
				IDX_CH0_COUNT_LOW: next_rdata[7:0] = low_byte(err_count[0]);
				IDX_CH0_COUNT_HIGH: next_rdata[7:0] = high_byte(err_count[0]);
				IDX_JITTER_CONFIG: next_rdata[7:0] = {5'h00, jitter_config};
				IDX_POS_PEAK_LOW: next_rdata[7:0] = pos_peak[7:0];
				IDX_POS_PEAK_HIGH: next_rdata[7:0] = {4'h0, pos_peak[11:8]};
				IDX_NEG_PEAK_LOW: next_rdata[7:0] = neg_peak[7:0];
				IDX_NEG_PEAK_HIGH: next_rdata[7:0] = {4'h0, neg_peak[11:8]};
				IDX_ERROR_CONFIG: next_rdata[7:0] = {6'h00, count_update_select, 1'b0};
				IDX_EDGE_SELECT: next_rdata[7:0] = {2'b00, edge_select};
				IDX_IRQ_SUMMARY: next_rdata[15:0] = irq_summary;
				IDX_IRQ_CLEAR: next_rdata = 32'h0000_0000;
				IDX_IRQ_ENABLE: next_rdata[15:0] = irq_enable;
				default: next_rresp = RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= next_rdata;
			s_axi_rresp <= next_rresp;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule

// ### bench/les_line_error_regs_chk.sv
// les_line_error_regs_chk: bus timing and interrupt output checks at the block ports.
// assumes one clock domain; bound to les_line_error_regs at the foot of this file.
`timescale 1ns/1ps
module les_line_error_regs_chk (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic period_select,
	input wire logic band_select,
	input wire logic count_update_select,
	input wire logic irq
);
	import les_pkg::*;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##[1:2] s_axi_bvalid)
		else $error("write answer late");
	a_bresp_code: assert property (s_axi_bvalid |-> s_axi_bresp == RESP_OKAY
		|| s_axi_bresp == RESP_SLVERR)
		else $error("bad write response code");
	a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write accepted while response pending");
	a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read accepted while data pending");
	a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
		else $error("upper read data not zero");
	a_cfg_on_write: assert property ($changed(period_select) || $changed(band_select)
		|| $changed(count_update_select) |-> s_axi_bvalid || $past(s_axi_bvalid))
		else $error("config output moved without a write");
	a_irq_fall_write: assert property ($fell(irq) |-> s_axi_bvalid
		|| $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
		else $error("irq dropped without a write");
endmodule

bind les_line_error_regs les_line_error_regs_chk u_chk (
	.clk_sys(clk_sys),
	.rst(rst),
	.s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid),
	.period_select(period_select),
	.band_select(band_select),
	.count_update_select(count_update_select),
	.irq(irq)
);

// ### bench/testbench.sv
// testbench: drives the line error register group over axi4-lite and its event inputs.
// assumes the checker binds itself; one 250 mhz clock, registers at byte address 4*index.
`timescale 1ns/1ps
module testbench;
	import les_pkg::*;
	logic clk_sys, rst, awvalid, wvalid, bready, arvalid, rready, round_end, tick;
	logic awready, wready, bvalid, arready, rvalid, irq, psel, bsel, csel;
	logic [12:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0] bresp, rresp;
	logic [15:1] src [1:5];
	logic [15:0] errp;
	logic [11:0] pos, neg;
	int num_errors, n_tests, seed;

	les_line_error_regs u_dut (
		.clk_sys(clk_sys), .rst(rst),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .sys_bipolar_viol(src[5]), .line_bipolar_viol(src[4]),
		.sys_excess_zero(src[3]), .line_excess_zero(src[2]), .pattern_error(src[1]),
		.err_pulse(errp), .count_round_end(round_end), .jit_pos_peak(pos),
		.jit_neg_peak(neg), .jit_second_tick(tick), .period_select(psel),
		.band_select(bsel), .count_update_select(csel), .irq(irq)
	);

	initial begin
		clk_sys = 1'h0;
		forever #2 clk_sys = ~clk_sys;
	end

	// index of a channel's status register
	function automatic logic [10:0] st_idx(input int ch);
		return 11'h022 + 11'(ch - 1) * 11'h040;
	endfunction

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [10:0] idx, input logic [31:0] d, output logic [1:0] r);
		r = 2'h0;
		@(posedge clk_sys);
		awaddr <= {idx, 2'h0};
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		for (int k = 0; k < 100; k++) begin
			@(posedge clk_sys);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
			if (bvalid) begin
				r = bresp;
				bready <= 1'h0;
				break;
			end
		end
	endtask

	task automatic rd(input logic [10:0] idx, output logic [31:0] d, output logic [1:0] r);
		d = 32'h0;
		r = 2'h0;
		@(posedge clk_sys);
		araddr <= {idx, 2'h0};
		arvalid <= 1'h1;
		rready <= 1'h1;
		for (int k = 0; k < 100; k++) begin
			@(posedge clk_sys);
			if (arready) arvalid <= 1'h0;
			if (rvalid) begin
				d = rdata;
				r = rresp;
				rready <= 1'h0;
				break;
			end
		end
	endtask

	task automatic put(input logic [10:0] idx, input logic [31:0] d);
		logic [1:0] r;
		wr(idx, d, r);
		check(32'(r), 32'(RESP_OKAY), "write response");
	endtask

	task automatic rd_chk(input logic [10:0] idx, input logic [31:0] exp, input string what);
		logic [31:0] d;
		logic [1:0] r;
		rd(idx, d, r);
		check(d, exp, what);
		check(32'(r), 32'(RESP_OKAY), "read response");
	endtask

	task automatic errs(input int ch, input int cnt);
		errp[ch] <= 1'h1;
		repeat (cnt) @(posedge clk_sys);
		errp[ch] <= 1'h0;
		round_end <= 1'h1;
		@(posedge clk_sys);
		round_end <= 1'h0;
	endtask

	task automatic summarize;
		$display("comparisons %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// about 70k cycles of work, limit near 100k
	initial begin
		#400000;
		num_errors++;
		summarize();
	end

	initial begin
		logic [31:0] d;
		logic [1:0] r;
		int ch, n;
		seed = 17;
		{awvalid, wvalid, bready, arvalid, rready, round_end, tick} = 7'h0;
		{awaddr, araddr, wdata, errp, pos, neg} = 98'h0;
		foreach (src[i]) src[i] = 15'h0;
		rst = 1'h1;
		repeat (6) @(posedge clk_sys);
		rst <= 1'h0;
		rd_chk(IDX_JITTER_CONFIG, 32'h0, "config reset");
		rd_chk(IDX_CH0_COUNT_LOW, 32'h0, "count low reset");
		rd_chk(IDX_CH0_COUNT_HIGH, 32'h0, "count high reset");
		rd_chk(st_idx(15), 32'h0, "status reset");
		check(32'(irq), 32'h0, "irq reset");
		$display("test reset done");
		for (int b = 1; b <= 5; b++) begin
			ch = (b == 5) ? 15 : 1 + ($unsigned($random(seed)) % 15);
			src[b][ch] <= 1'h1;
			repeat (3) @(posedge clk_sys);
			rd_chk(st_idx(ch), 32'h1 << b, "flag set");
			check(32'(irq), 32'h1, "irq set");
			put(st_idx(ch), 32'h1 << b);
			// source falls only after the clear, so a falling set would show
			src[b][ch] <= 1'h0;
			rd_chk(st_idx(ch), 32'h0, "flag cleared, fall ignored");
			check(32'(irq), 32'h0, "irq released");
		end
		$display("test flags done");
		put(IDX_EDGE_SELECT, 32'h3f);
		src[1][7] <= 1'h1;
		repeat (3) @(posedge clk_sys);
		put(st_idx(7), 32'h2);
		src[1][7] <= 1'h0;
		rd_chk(st_idx(7), 32'h2, "either edge");
		put(IDX_IRQ_ENABLE, 32'h0);
		repeat (2) @(posedge clk_sys);
		check(32'(irq), 32'h0, "irq masked");
		put(IDX_IRQ_ENABLE, 32'hffff);
		repeat (2) @(posedge clk_sys);
		check(32'(irq), 32'h1, "irq unmasked");
		put(st_idx(7), 32'h2);
		put(IDX_EDGE_SELECT, 32'h0);
		$display("test edge and mask done");
		n = 1 + ($unsigned($random(seed)) % 600);
		errs(0, n);
		rd_chk(IDX_CH0_COUNT_LOW, 32'(n) & 32'hff, "count low");
		rd_chk(IDX_CH0_COUNT_HIGH, 32'(n) >> 8, "count high");
		put(IDX_ERROR_CONFIG, 32'h2);
		check(32'(csel), 32'h1, "manual select");
		errs(0, 3);
		rd_chk(IDX_CH0_COUNT_LOW, 32'(n) & 32'hff, "no auto load");
		put(IDX_ERROR_CONFIG, 32'h3);
		rd_chk(IDX_CH0_COUNT_LOW, 32'h3, "manual load");
		put(IDX_ERROR_CONFIG, 32'h0);
		errs(2, 65536);
		rd_chk(st_idx(2), 32'h1, "overflow flag");
		rd_chk(st_idx(2) + 11'h1, 32'hff, "full count low");
		rd_chk(st_idx(2) + 11'h2, 32'hff, "full count high");
		put(st_idx(2), 32'h1);
		$display("test counts done");
		d = $unsigned($random(seed)) & 32'hff;
		put(IDX_JITTER_CONFIG, d);
		rd_chk(IDX_JITTER_CONFIG, d & 32'h7, "config readback");
		check(32'(psel), 32'(d[1]), "period select");
		check(32'(bsel), 32'(d[0]), "band select");
		for (int b = 0; b < 2; b++) begin
			put(IDX_JITTER_CONFIG, 32'h0);
			pos <= 12'($random(seed));
			neg <= 12'($random(seed));
			put(IDX_JITTER_CONFIG, b ? 32'h2 : 32'h4);
			tick <= 1'(b);
			@(posedge clk_sys);
			tick <= 1'h0;
			rd_chk(IDX_POS_PEAK_LOW, 32'(pos[7:0]), "pos low");
			rd_chk(IDX_POS_PEAK_HIGH, 32'(pos[11:8]), "pos high");
			rd_chk(IDX_NEG_PEAK_LOW, 32'(neg[7:0]), "neg low");
			rd_chk(IDX_NEG_PEAK_HIGH, 32'(neg[11:8]), "neg high");
		end
		put(IDX_IRQ_CLEAR, 32'h1);
		rd_chk(IDX_IRQ_SUMMARY, 32'h0, "summary clear");
		check(32'(irq), 32'h0, "irq idle");
		rd(11'h7ff, d, r);
		check(d, 32'h0, "unmapped data");
		check(32'(r), 32'(RESP_SLVERR), "unmapped read");
		wr(11'h7ff, 32'h0, r);
		check(32'(r), 32'(RESP_SLVERR), "unmapped write");
		$display("test jitter and map done");
		summarize();
	end
endmodule
